// *** verilog/prl_pkg.sv ***
package prl_pkg;
  // port geometry
  localparam int SEL_W = 3;
  localparam int DATA_W = 20;
  localparam int NUM_REGS = 8;
  localparam int DIGITS = 5;
  // value held by every working and stored register during reset, before the stored image is restored
  localparam logic [DATA_W-1:0] REG_RESET = 20'h00000;
  // minimum set-up and hold of the external party, in microseconds
  localparam int SETUP_US = 5000;
  localparam int HOLD_US = 5000;
  localparam int CLK_MHZ = 250;
  localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
  localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
  // capture sequence states
  typedef enum logic [2:0] {
    PRL_IDLE = 3'h1,
    PRL_CAPT = 3'h2,
    PRL_WAIT = 3'h4
  } prl_state_t;
endpackage

// *** verilog/prl_load_port.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - three select lines address eight registers
// - twenty data lines carry one word
// - data read as BCD or binary
// - capture on strobe rising edge
// - captured value applied to working register immediately
// - store pulse copies registers to non-volatile copy
// - no maximum interval before or after strobe
// - dedicated input enables simulated line axis
// - uncommitted values lost at power loss
// - read-and-activate input also loads the word
module prl_load_port
  import prl_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // parallel load connector pins
  input wire logic [SEL_W-1:0] register_select_lines,
  input wire logic [DATA_W-1:0] load_data,
  input wire logic load_strobe,
  input wire logic read_activate,
  input wire logic store_pulse,
  input wire logic virtual_axis_pin,
  input wire logic bcd_format,
  // restored image from non-volatile memory at power-up
  input wire logic [NUM_REGS*DATA_W-1:0] nv_image,
  // outputs to the controlling process
  output logic [NUM_REGS*DATA_W-1:0] work_regs,
  output logic [NUM_REGS*DATA_W-1:0] nv_regs,
  output logic load_done,
  output logic store_done,
  output logic virtual_axis_on
);

  // converts five bcd digits into a binary value; digits above nine are
  // weighted as they stand rather than refused
  function automatic logic [DATA_W-1:0] bcd_to_bin(input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] acc;
    acc = '0;
    for (int i = DIGITS - 1; i >= 0; i--)
    begin
      acc = DATA_W'(acc * 10) + DATA_W'(d[i*4 +: 4]);
    end
    return acc;
  endfunction

  // pin synchronisers, two stages each
  logic [SEL_W-1:0] sel_s1_r, sel_s2_r;
  logic [DATA_W-1:0] dat_s1_r, dat_s2_r;
  logic [4:0] ctl_s1_r, ctl_s2_r;
  logic [4:0] ctl_s1_nxt, ctl_s2_nxt;
  logic strb_d_r, rda_d_r, sto_d_r;
  logic strb_d_nxt, rda_d_nxt, sto_d_nxt;

  // next values of the control pipeline; the delayed copies feed the edge
  // detectors, so a pin already high when reset ends counts as one rising edge
  always_comb
  begin
    ctl_s1_nxt = {bcd_format, virtual_axis_pin, store_pulse, read_activate, load_strobe};
    ctl_s2_nxt = ctl_s1_r;
    strb_d_nxt = ctl_s2_r[0];
    rda_d_nxt = ctl_s2_r[1];
    sto_d_nxt = ctl_s2_r[2];
  end

  // two stages per pin; only the second stage is read by any logic, and a
  // low clk_en holds every stage
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sel_s1_r <= '0;
      sel_s2_r <= '0;
      dat_s1_r <= '0;
      dat_s2_r <= '0;
      ctl_s1_r <= '0;
      ctl_s2_r <= '0;
      strb_d_r <= 1'b0;
      rda_d_r <= 1'b0;
      sto_d_r <= 1'b0;
    end
    else if (clk_en)
    begin
      sel_s1_r <= register_select_lines;
      sel_s2_r <= sel_s1_r;
      dat_s1_r <= load_data;
      dat_s2_r <= dat_s1_r;
      ctl_s1_r <= ctl_s1_nxt;
      ctl_s2_r <= ctl_s2_nxt;
      strb_d_r <= strb_d_nxt;
      rda_d_r <= rda_d_nxt;
      sto_d_r <= sto_d_nxt;
    end
  end

  // edge events on the synchronised controls; read_activate acts as a second
  // strobe, and an edge that lands while a capture is in flight is dropped
  logic load_evt, store_evt;
  assign load_evt = (ctl_s2_r[0] & ~strb_d_r) | (ctl_s2_r[1] & ~rda_d_r);
  assign store_evt = ctl_s2_r[2] & ~sto_d_r;

  // capture sequence: latch word, then write the addressed register
  prl_state_t state_r, state_nxt;
  logic [SEL_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] word_r, word_nxt;
  logic [DATA_W-1:0] work_r [NUM_REGS];
  logic [DATA_W-1:0] work_nxt [NUM_REGS];
  logic [DATA_W-1:0] nv_r [NUM_REGS];
  logic [DATA_W-1:0] nv_nxt [NUM_REGS];
  logic load_done_r, load_done_nxt, store_done_r, store_done_nxt;
  logic virt_r, virt_nxt;
  // low during reset and in the first cycle after it, in which the stored image is restored
  logic restored_r, restored_nxt;

  always_comb
  begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    word_nxt = word_r;
    work_nxt = work_r;
    nv_nxt = nv_r;
    load_done_nxt = 1'b0;
    store_done_nxt = 1'b0;
    restored_nxt = 1'b1;
    virt_nxt = ctl_s2_r[3];
    // working copy comes from the stored image once after reset
    if (!restored_r)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        nv_nxt[i] = nv_image[i*DATA_W +: DATA_W];
        work_nxt[i] = nv_image[i*DATA_W +: DATA_W];
      end
    end
    // one capture per edge detected in PRL_IDLE: latch, write, then one quiet cycle
    case (state_r)
      PRL_IDLE:
      begin
        if (load_evt && restored_r)
        begin
          addr_nxt = sel_s2_r;
          word_nxt = ctl_s2_r[4] ? bcd_to_bin(dat_s2_r) : dat_s2_r;
          state_nxt = PRL_CAPT;
        end
      end
      PRL_CAPT:
      begin
        work_nxt[addr_r] = word_r;
        load_done_nxt = 1'b1;
        state_nxt = PRL_WAIT;
      end
      PRL_WAIT:
      begin
        // quiet cycle keeps accepted edges at least three cycles apart
        state_nxt = PRL_IDLE;
      end
      default:
      begin
        state_nxt = PRL_IDLE;
      end
    endcase
    // a store in the cycle of a write copies the word being written, so the
    // stored image never lags a load that completes in the same cycle
    if (store_evt && restored_r)
    begin
      nv_nxt = work_nxt;
      store_done_nxt = 1'b1;
    end
  end

  // state registers; reset clears both copies until the stored image returns
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r <= PRL_IDLE;
      addr_r <= '0;
      word_r <= REG_RESET;
      for (int i = 0; i < NUM_REGS; i++)
      begin
        work_r[i] <= REG_RESET;
        nv_r[i] <= REG_RESET;
      end
      load_done_r <= 1'b0;
      store_done_r <= 1'b0;
      virt_r <= 1'b0;
      restored_r <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      word_r <= word_nxt;
      work_r <= work_nxt;
      nv_r <= nv_nxt;
      load_done_r <= load_done_nxt;
      store_done_r <= store_done_nxt;
      virt_r <= virt_nxt;
      restored_r <= restored_nxt;
    end
  end

  // flatten register arrays onto outputs
  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
    begin
      work_regs[i*DATA_W +: DATA_W] = work_r[i];
      nv_regs[i*DATA_W +: DATA_W] = nv_r[i];
    end
  end
  // pulses and the axis level leave straight from their flops
  assign load_done = load_done_r;
  assign store_done = store_done_r;
  assign virtual_axis_on = virt_r;

endmodule

// *** verif/prl_checker.sv ***
`timescale 1ns/1ps
module prl_checker
  import prl_pkg::*;
(
  // watched pins
  input logic sys_clk,
  input logic rst,
  input logic load_strobe,
  input logic read_activate,
  input logic store_pulse,
  input logic virtual_axis_pin,
  input logic [NUM_REGS*DATA_W-1:0] work_regs,
  input logic [NUM_REGS*DATA_W-1:0] nv_regs,
  input logic load_done,
  input logic store_done,
  input logic virtual_axis_on
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // answer timing and quiet registers
  a_load_ack: assert property ($rose(load_strobe) |-> ##[4:5] load_done)
    else $error("late");
  a_read_ack: assert property ($rose(read_activate) |-> ##[4:5] load_done)
    else $error("late");
  a_store_ack: assert property ($rose(store_pulse) |-> ##[3:4] store_done)
    else $error("late");
  a_axis_lag: assert property ($rose(virtual_axis_pin) |-> ##3 virtual_axis_on)
    else $error("axis");
  a_axis_follow: assert property (!$past(rst, 3) |->
    virtual_axis_on == $past(virtual_axis_pin, 3))
    else $error("axis level");
  a_one_load: assert property (load_done |=> !load_done)
    else $error("twice");
  a_work_held: assert property (!load_done && !$past(rst, 2) |-> $stable(work_regs))
    else $error("moved");
  a_nv_held: assert property (!store_done && !$past(rst, 2) |-> $stable(nv_regs))
    else $error("moved");
  a_nv_copy: assert property (store_done |-> nv_regs == work_regs)
    else $error("copy");
endmodule
bind prl_load_port prl_checker i_chk (.*);

// *** verif/prl_party.sv ***
`timescale 1ns/1ps
module prl_party
  import prl_pkg::*;
(
  // connector lines
  input logic sys_clk,
  output logic [2:0] sel,
  output logic [19:0] word,
  output logic [2:0] pins
);
  initial {sel, word, pins} = 0;
  // lines settle, one pin pulses, data wanders once the hold has run out
  task automatic xfer(input logic [2:0] s, input logic [19:0] w, input int k);
    {sel, word} = {s, w};
    repeat (8) @(negedge sys_clk);
    pins[k] = 1'b1;
    repeat (8) @(negedge sys_clk);
    word = ~w;
    repeat (8) @(negedge sys_clk);
    {sel, word, pins[k]} = {~s, w, 1'b0};
    repeat (8) @(negedge sys_clk);
  endtask
endmodule

// *** verif/prl_load_port_test.sv ***
`timescale 1ns/1ps
module prl_load_port_test
  import prl_pkg::*;
();
  logic sys_clk = 0;
  logic rst, virtual_axis_pin, bcd_format, load_done, store_done, axis_on;
  logic [2:0] register_select_lines, pins;
  logic [19:0] load_data, w;
  logic [159:0] nv_image, work_regs, nv_regs, mdl;
  logic [160:0] q[$], e;
  logic [31:0] s = 32'h7632FDBC;
  int bad_count, n_compared, cyc;
  // block under test and the far-side party
  prl_load_port i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .register_select_lines(register_select_lines), .load_data(load_data),
    .load_strobe(pins[0]), .read_activate(pins[1]), .store_pulse(pins[2]),
    .virtual_axis_pin(virtual_axis_pin), .bcd_format(bcd_format), .nv_image(nv_image),
    .work_regs(work_regs), .nv_regs(nv_regs), .load_done(load_done),
    .store_done(store_done), .virtual_axis_on(axis_on));
  prl_party i_party (.sys_clk, .sel(register_select_lines), .word(load_data), .pins);
  // xorshift source and five-digit decode, lowest digit in bits 3:0
  function logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function logic [19:0] dec(input logic [19:0] v);
    dec = 0;
    for (int d = 4; d >= 0; d--)
      dec = dec * 10 + v[d*4 +: 4];
  endfunction
  // comparison and verdict
  task automatic chk(input logic [159:0] a, b);
    n_compared++;
    if (a !== b)
    begin
      bad_count++;
      $display("MISMATCH %0t image", $time);
    end
  endtask
  task results;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // power cycle, after which the stored image is the working image
  task boot;
    rst = 1;
    repeat (16) @(negedge sys_clk);
    rst = 0;
    repeat (3) @(negedge sys_clk);
    mdl = nv_image;
    chk(work_regs, mdl);
    chk(nv_regs, mdl);
  endtask
  initial forever #2 sys_clk = ~sys_clk;
  // oldest note against each completion; hang limit
  always @(negedge sys_clk)
  begin
    if (++cyc > 3000)
    begin
      bad_count++;
      results();
    end
    else if (load_done === 1'b1 || store_done === 1'b1)
    begin
      e = q.pop_front();
      chk(e[160] ? nv_regs : work_regs, e[159:0]);
      chk(160'(axis_on), 160'(virtual_axis_pin));
    end
  end
  // every address in both formats, a store, then one load lost at power-off
  initial
  begin
    {virtual_axis_pin, bcd_format} = 0;
    nv_image = {xs(), xs(), xs(), xs(), xs()};
    boot();
    for (int i = 0; i < 18; i++)
    begin
      w = 20'(xs());
      {bcd_format, virtual_axis_pin} = {i[3], i[2]};
      if (i == 16)
        nv_image = mdl;
      else
        mdl[i[2:0]*20 +: 20] = bcd_format ? dec(w) : w;
      q.push_back({i == 16, mdl});
      i_party.xfer(i[2:0], w, i == 16 ? 2 : i[0]);
    end
    boot();
    results();
  end
endmodule
